// ==== inc/pwm_pkg.sv ====
// Constants, register map and carrier types for the 16-bit PWM timer
// Function
// - Modes 5,6,7,14,15 count up from zero to TOP, then restart.
// - Single-slope TOP is 0x00FF/0x01FF/0x03FF, capture top, or compare A.
// - Single-slope: after count equals TOP, counter clears on next tick.
// - Single-slope action 2 clears on match, sets at zero; 3 opposite.
// - Single-slope: overflow flag set on each tick the count reaches TOP.
// - Single-slope: compare A or capture flag set with overflow if TOP.
// - Any PWM mode: channel flag set whenever count equals its compare.
// - Fixed TOP modes mask compare bits above TOP width on writes.
// - Capture top acts at once; if below count, run to 0xFFFF and wrap.
// - PWM compare writes go to buffer; active compare stays undisturbed.
// - Single-slope: buffer copied to active compare at TOP match tick.
// - Single-slope: compare 0 gives one-tick spike; compare TOP constant.
// - Mode 15 action 1 toggles output A each match, buffered updates kept.
// - Modes 1,2,3,10,11 count 0 up to TOP then down to zero, repeating.
// - Dual TOP fixed or capture or compare A; held one tick at TOP.
// - Dual: non-inverting clears on up match, sets on down; inverting opposite.
// - Dual-slope: overflow flag set each time the counter reaches zero.
// - Dual: buffers load at TOP; compare A or capture flag set then.
// - Dual: compare zero keeps output low, TOP keeps high; inverted opposite.
// - Mode 11 with action 1 toggles output A on each match.
// - Action setting 0 leaves the output register untouched at match.
// - Reset clears each waveform output register to zero.
package pwm_pkg;
    localparam int CNT_W = 16;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [3:0] MODE_PC_CAP = 4'hA;
    localparam logic [3:0] MODE_PC_CMPA = 4'hB;
    localparam logic [3:0] MODE_FAST_CAP = 4'hE;
    localparam logic [3:0] MODE_FAST_CMPA = 4'hF;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_NONINV = 2'h2;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_CMPA = 8'h08;
    localparam logic [7:0] OFF_CMPB = 8'h0C;
    localparam logic [7:0] OFF_CAPTOP = 8'h10;
    localparam logic [7:0] OFF_FLAGS = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [9:0] DIV1_MASK = 10'h000;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [2:0] clk_sel;
        logic [1:0] pin_direction_bit;
        logic [1:0] output_action_select_b;
        logic [1:0] output_action_select_a;
        logic [3:0] waveform_mode_select;
    } ctrl_t;
    typedef struct packed {
        logic capture_flag;
        logic cmp_b_flag;
        logic cmp_a_flag;
        logic overflow_flag;
    } flags_t;
    localparam ctrl_t CTRL_RST = '0;
    localparam flags_t FLAGS_RST = '0;
    localparam logic [15:0] CAPTOP_RST = 16'h0000;
endpackage : pwm_pkg

// ==== verilog/timer16_pwm.sv ====
// 16-bit timer with single- and dual-slope PWM, AXI4-Lite registers
`timescale 1ns/1ps
module timer16_pwm (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic waveform_output_a,
    output logic waveform_output_b,
    output logic waveform_oe_a,
    output logic waveform_oe_b
);
    localparam int NCH = 2;

    pwm_pkg::ctrl_t ctrl_r;
    pwm_pkg::flags_t flags_r;
    pwm_pkg::flags_t flags_set;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic up_r;
    logic [15:0] cap_top_r;
    logic [9:0] pre_r;
    logic [15:0] cmp_buf_r [NCH];
    logic [15:0] cmp_act_r [NCH];
    logic [NCH-1:0] out_r;
    logic [NCH-1:0] match;

    // AXI4-Lite slave state
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        return (old & ~m) | (nw & m);
    endfunction : merge

    wire wr_fire = aw_got_r && w_got_r && !bvalid;
    wire [31:0] wmask = merge(32'h0000_0000, 32'hFFFF_FFFF, wstrb_r);
    wire wr_ctrl = wr_fire && (waddr_r == pwm_pkg::OFF_CTRL);
    wire wr_cap = wr_fire && (waddr_r == pwm_pkg::OFF_CAPTOP);
    wire wr_flags = wr_fire && (waddr_r == pwm_pkg::OFF_FLAGS);
    wire wr_ok = (waddr_r == pwm_pkg::OFF_CTRL)
              || (waddr_r == pwm_pkg::OFF_COUNT)
              || (waddr_r == pwm_pkg::OFF_CMPA)
              || (waddr_r == pwm_pkg::OFF_CMPB)
              || (waddr_r == pwm_pkg::OFF_CAPTOP)
              || (waddr_r == pwm_pkg::OFF_FLAGS)
              || (waddr_r == pwm_pkg::OFF_STATUS);

    // Mode decode
    wire [3:0] mode = ctrl_r.waveform_mode_select;
    wire fixed = !mode[3] && (mode[1:0] != 2'h0);
    wire fast = fixed ? mode[2] : (mode == pwm_pkg::MODE_FAST_CAP)
                || (mode == pwm_pkg::MODE_FAST_CMPA);
    wire dual = fixed ? !mode[2] : (mode == pwm_pkg::MODE_PC_CAP)
                || (mode == pwm_pkg::MODE_PC_CMPA);
    wire pwm = fast || dual;
    wire top_cap = (mode == pwm_pkg::MODE_FAST_CAP)
                || (mode == pwm_pkg::MODE_PC_CAP);
    wire top_cmpa = (mode == pwm_pkg::MODE_FAST_CMPA)
                 || (mode == pwm_pkg::MODE_PC_CMPA);
    wire [15:0] fix_top = (mode[1:0] == 2'h1) ? pwm_pkg::TOP_8BIT :
                          (mode[1:0] == 2'h2) ? pwm_pkg::TOP_9BIT :
                          pwm_pkg::TOP_10BIT;
    // Fixed and capture TOP apply at once; compare A TOP uses active copy
    wire [15:0] top = fixed ? fix_top :
                      top_cap ? cap_top_r :
                      top_cmpa ? cmp_act_r[0] : pwm_pkg::COUNT_MAX;
    wire [15:0] cmp_mask = fixed ? fix_top : pwm_pkg::COUNT_MAX;
    wire at_top = (cnt_r == top);
    wire at_zero = (cnt_r == pwm_pkg::COUNT_ZERO);

    // Prescaler tick
    wire run = (ctrl_r.clk_sel != 3'h0);
    wire [9:0] div_mask = (ctrl_r.clk_sel == 3'h1) ? pwm_pkg::DIV1_MASK :
                          (ctrl_r.clk_sel == 3'h2) ? pwm_pkg::DIV8_MASK :
                          (ctrl_r.clk_sel == 3'h3) ? pwm_pkg::DIV64_MASK :
                          (ctrl_r.clk_sel == 3'h4) ? pwm_pkg::DIV256_MASK :
                          pwm_pkg::DIV1024_MASK;
    wire tick = run && ((pre_r & div_mask) == div_mask);

    // Counter events
    wire fast_wrap = tick && fast && at_top;
    wire dual_peak = tick && dual && up_r && at_top;
    wire dual_floor = tick && dual && !up_r && at_zero;
    wire load = fast_wrap || dual_peak;
    wire free_wrap = tick && !pwm && (cnt_r == pwm_pkg::COUNT_MAX);

    always_comb begin
        cnt_nxt = cnt_r;
        if (!tick) begin
            cnt_nxt = cnt_r;
        end else if (fast) begin
            cnt_nxt = at_top ? pwm_pkg::COUNT_ZERO : 16'(cnt_r + 16'h1);
        end else if (dual && up_r) begin
            cnt_nxt = at_top ? 16'(cnt_r - 16'h1) : 16'(cnt_r + 16'h1);
        end else if (dual) begin
            cnt_nxt = at_zero ? 16'h0001 : 16'(cnt_r - 16'h1);
        end else begin
            cnt_nxt = 16'(cnt_r + 16'h1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            up_r <= 1'b1;
            pre_r <= 10'h000;
        end else begin
            cnt_r <= cnt_nxt;
            pre_r <= run ? 10'(pre_r + 10'h1) : 10'h000;
            if (!dual) begin
                up_r <= 1'b1;
            end else if (dual_peak) begin
                up_r <= 1'b0;
            end else if (dual_floor) begin
                up_r <= 1'b1;
            end
        end
    end

    // Compare channels
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            wire [1:0] act = (gi == 0) ? ctrl_r.output_action_select_a
                                       : ctrl_r.output_action_select_b;
            wire [7:0] off = (gi == 0) ? pwm_pkg::OFF_CMPA
                                       : pwm_pkg::OFF_CMPB;
            wire wr_cmp = wr_fire && (waddr_r == off);
            wire [31:0] cmp_wr = merge({16'h0000, cmp_buf_r[gi]},
                                       wdata_r, wstrb_r);
            wire [15:0] cmp = cmp_act_r[gi];
            wire tgl = (gi == 0) && (act == pwm_pkg::ACT_TOGGLE)
                       && top_cmpa;
            wire pwm_act = act[1];
            wire dual_lvl = (cmp == top) ? 1'b1 :
                            (cmp == pwm_pkg::COUNT_ZERO) ? 1'b0 : !up_r;
            assign match[gi] = tick && (cnt_r == cmp);
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cmp_buf_r[gi] <= 16'h0000;
                    cmp_act_r[gi] <= 16'h0000;
                    out_r[gi] <= 1'b0;
                end else begin
                    if (wr_cmp) begin
                        cmp_buf_r[gi] <= cmp_wr[15:0] & cmp_mask;
                    end
                    if (load || !pwm) begin
                        cmp_act_r[gi] <= cmp_buf_r[gi];
                    end
                    // Set at zero wins over match so compare TOP is constant
                    if (fast && fast_wrap && pwm_act) begin
                        out_r[gi] <= !act[0];
                    end else if (fast && match[gi] && pwm_act) begin
                        out_r[gi] <= act[0];
                    end else if (dual && match[gi] && pwm_act) begin
                        out_r[gi] <= dual_lvl ^ act[0];
                    end else if (pwm && match[gi] && tgl) begin
                        out_r[gi] <= !out_r[gi];
                    end
                end
            end
        end
    endgenerate

    // Flags: hardware set wins over software clear
    always_comb begin
        flags_set.overflow_flag = fast_wrap || dual_floor || free_wrap;
        flags_set.cmp_a_flag = match[0] || (load && top_cmpa);
        flags_set.cmp_b_flag = match[1];
        flags_set.capture_flag = load && top_cap;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= pwm_pkg::CTRL_RST;
            flags_r <= pwm_pkg::FLAGS_RST;
            cap_top_r <= pwm_pkg::CAPTOP_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= 13'(merge({19'h0, ctrl_r}, wdata_r, wstrb_r));
            end
            if (wr_cap) begin
                cap_top_r <= 16'(merge({16'h0, cap_top_r}, wdata_r,
                                       wstrb_r));
            end
            flags_r <= (wr_flags ? (flags_r & ~wdata_r[3:0] & ~wmask[3:0])
                                 | (flags_r & ~(wdata_r[3:0] & wmask[3:0]))
                                 : flags_r) | flags_set;
        end
    end

    // AXI4-Lite write channel
    assign awready = !aw_got_r && !bvalid;
    assign wready = !w_got_r && !bvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid <= 1'b0;
            bresp <= pwm_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_got_r <= 1'b1;
                waddr_r <= {awaddr[7:2], 2'b00};
            end
            if (wvalid && wready) begin
                w_got_r <= 1'b1;
                wdata_r <= wdata;
                wstrb_r <= wstrb;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    wire [7:0] raddr = {araddr[7:2], 2'b00};
    wire rd_ok = (raddr == pwm_pkg::OFF_CTRL) || (raddr == pwm_pkg::OFF_COUNT)
              || (raddr == pwm_pkg::OFF_CMPA) || (raddr == pwm_pkg::OFF_CMPB)
              || (raddr == pwm_pkg::OFF_CAPTOP)
              || (raddr == pwm_pkg::OFF_FLAGS)
              || (raddr == pwm_pkg::OFF_STATUS);
    wire [31:0] rd_val =
        (raddr == pwm_pkg::OFF_CTRL) ? {19'h0, ctrl_r} :
        (raddr == pwm_pkg::OFF_COUNT) ? {16'h0, cnt_r} :
        (raddr == pwm_pkg::OFF_CMPA) ? {16'h0, cmp_buf_r[0]} :
        (raddr == pwm_pkg::OFF_CMPB) ? {16'h0, cmp_buf_r[1]} :
        (raddr == pwm_pkg::OFF_CAPTOP) ? {16'h0, cap_top_r} :
        (raddr == pwm_pkg::OFF_FLAGS) ? {28'h0, flags_r} :
        (raddr == pwm_pkg::OFF_STATUS) ? {29'h0, !up_r, out_r} :
        32'h0000_0000;
    assign arready = !rvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= pwm_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= rd_val;
            rresp <= rd_ok ? pwm_pkg::RESP_OKAY : pwm_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    assign waveform_output_a = out_r[0];
    assign waveform_output_b = out_r[1];
    assign waveform_oe_a = ctrl_r.pin_direction_bit[0]
                           && (ctrl_r.output_action_select_a != 2'h0);
    assign waveform_oe_b = ctrl_r.pin_direction_bit[1]
                           && (ctrl_r.output_action_select_b != 2'h0);

    // Checks
    AST_FAST_CLEAR: assert property (@(posedge clk) disable iff (rst)
        fast_wrap |=> cnt_r == 16'h0000)
        else $error("count not cleared after TOP");
    AST_FAST_OVF: assert property (@(posedge clk) disable iff (rst)
        fast_wrap |=> flags_r.overflow_flag)
        else $error("overflow flag missing at TOP");
    AST_DUAL_HOLD: assert property (@(posedge clk) disable iff (rst)
        dual_peak |=> !up_r && cnt_r == 16'($past(cnt_r) - 16'h1))
        else $error("dual slope did not reverse at TOP");
    AST_DUAL_OVF: assert property (@(posedge clk) disable iff (rst)
        dual_floor |=> flags_r.overflow_flag && up_r)
        else $error("overflow flag missing at zero");
    AST_LOAD: assert property (@(posedge clk) disable iff (rst)
        (load && !wr_fire) |=> cmp_act_r[0] == $past(cmp_buf_r[0]))
        else $error("buffered compare not loaded at TOP");
    AST_NO_LOAD: assert property (@(posedge clk) disable iff (rst)
        (pwm && !load && $past(pwm)) |=> $stable(cmp_act_r[1]))
        else $error("active compare changed between TOPs");
    AST_CMP_FLAG: assert property (@(posedge clk) disable iff (rst)
        match[1] |=> flags_r.cmp_b_flag)
        else $error("compare flag B not set on match");
    AST_HOLD: assert property (@(posedge clk) disable iff (rst)
        !tick |=> cnt_r == $past(cnt_r))
        else $error("counter moved without tick");
    AST_ACT0: assert property (@(posedge clk) disable iff (rst)
        ctrl_r.output_action_select_a == pwm_pkg::ACT_NONE
        |=> out_r[0] == $past(out_r[0]))
        else $error("output changed with action zero");
    AST_FAST_SET: assert property (@(posedge clk) disable iff (rst)
        (fast_wrap && ctrl_r.output_action_select_a == pwm_pkg::ACT_NONINV)
        |=> out_r[0])
        else $error("non-inverting output not set at zero");
    COV_FAST_WRAP: cover property (@(posedge clk) disable iff (rst)
        fast_wrap ##1 cnt_r == 16'h0000);
    COV_DUAL_CYCLE: cover property (@(posedge clk) disable iff (rst)
        dual_peak ##[1:1000] dual_floor);
    COV_TOGGLE: cover property (@(posedge clk) disable iff (rst)
        match[0] && g_ch[0].tgl ##1 out_r[0] != $past(out_r[0]));
endmodule : timer16_pwm

// ==== tb/timer16_pwm_bench.sv ====
// Self-checking bench for the 16-bit PWM timer over its register bus
`timescale 1ns/1ps
module timer16_pwm_bench;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] awaddr = 8'h00;
    logic awvalid = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic [7:0] araddr = 8'h00;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic out_a, out_b, oe_a, oe_b;
    logic [33:0] exp_q[$];
    int error_cnt = 0;
    int check_count = 0;
    logic [15:0] ha, hb;
    logic [31:0] rv;
    int i, k;

    timer16_pwm timer16_pwm_i (
        .clk(clk), .rst(rst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .waveform_output_a(out_a), .waveform_output_b(out_b),
        .waveform_oe_a(oe_a), .waveform_oe_b(oe_b)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic cmp_bus(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_bus

    task automatic cmp_wave(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_wave

    task automatic take(input logic [33:0] got);
        if (exp_q.size() == 0) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=none", $time, got);
        end else begin
            cmp_bus(got, exp_q.pop_front());
        end
    endtask : take

    // Monitor: each bus answer is matched against the oldest note
    always @(posedge clk) begin
        if (rvalid === 1'h1 && rready === 1'h1) begin
            take({rresp, rdata});
        end
        if (bvalid === 1'h1 && bready === 1'h1) begin
            take({bresp, 32'h0});
        end
    end

    function automatic logic [33:0] ok(input logic [31:0] v);
        return {pwm_pkg::RESP_OKAY, v};
    endfunction : ok

    function automatic logic [31:0] ctl(input logic [3:0] m,
            input logic [1:0] aa, input logic [1:0] ab, input logic [2:0] cs);
        pwm_pkg::ctrl_t c;
        c.clk_sel = cs;
        c.pin_direction_bit = 2'h3;
        c.output_action_select_b = ab;
        c.output_action_select_a = aa;
        c.waveform_mode_select = m;
        return 32'(c);
    endfunction : ctl

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] resp);
        logic aw_ok, w_ok, b_ok;
        exp_q.push_back({resp, 32'h0});
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        b_ok = 1'h0;
        while (b_ok !== 1'h1) begin
            @(negedge clk);
            aw_ok = awvalid & awready;
            w_ok = wvalid & wready;
            b_ok = bvalid & bready;
            @(posedge clk);
            if (aw_ok === 1'h1) awvalid <= 1'h0;
            if (w_ok === 1'h1) wvalid <= 1'h0;
        end
        bready <= 1'h0;
        @(posedge clk);
    endtask : axw

    task automatic axr(input logic [7:0] a, input logic [33:0] exp);
        logic ar_ok, r_ok;
        exp_q.push_back(exp);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        r_ok = 1'h0;
        while (r_ok !== 1'h1) begin
            @(negedge clk);
            ar_ok = arvalid & arready;
            r_ok = rvalid & rready;
            @(posedge clk);
            if (ar_ok === 1'h1) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        @(posedge clk);
    endtask : axr

    // Counts high cycles of both outputs over a window
    task automatic meas(input int p);
        ha = 16'h0;
        hb = 16'h0;
        repeat (p) begin
            @(negedge clk);
            if (out_a === 1'h1) ha++;
            if (out_b === 1'h1) hb++;
        end
        @(posedge clk);
    endtask : meas

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        void'($urandom(32'h5324));
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        cmp_wave({12'h0, out_a, out_b, oe_a, oe_b}, 16'h0);
        axr(pwm_pkg::OFF_CTRL, ok(32'h0));
        axr(pwm_pkg::OFF_FLAGS, ok(32'h0));
        axr(8'h1C, {pwm_pkg::RESP_SLVERR, 32'h0});
        axw(8'h1C, 32'hFFFF, pwm_pkg::RESP_SLVERR);
        $display("test reset done");
        for (i = 1; i < 8; i++) begin
            if (i == 4) continue;
            rv = $urandom;
            axw(pwm_pkg::OFF_CTRL, ctl(4'(i), 2'h2, 2'h2, 3'h0), 2'h0);
            axw(pwm_pkg::OFF_CMPB, rv, pwm_pkg::RESP_OKAY);
            axr(pwm_pkg::OFF_CMPB, ok({16'h0, rv[15:0] & ((i % 4 == 1) ?
                pwm_pkg::TOP_8BIT : (i % 4 == 2) ? pwm_pkg::TOP_9BIT :
                pwm_pkg::TOP_10BIT)}));
        end
        axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_FAST_CAP, 2'h2, 2'h3, 3'h0),
            pwm_pkg::RESP_OKAY);
        rv = $urandom;
        axw(pwm_pkg::OFF_CMPA, rv, pwm_pkg::RESP_OKAY);
        axr(pwm_pkg::OFF_CMPA, ok({16'h0, rv[15:0]}));
        axw(pwm_pkg::OFF_CAPTOP, rv, pwm_pkg::RESP_OKAY);
        axr(pwm_pkg::OFF_CAPTOP, ok({16'h0, rv[15:0]}));
        $display("test masking done");
        axw(pwm_pkg::OFF_CAPTOP, 32'h9, pwm_pkg::RESP_OKAY);
        axw(pwm_pkg::OFF_FLAGS, 32'hF, pwm_pkg::RESP_OKAY);
        for (k = 0; k < 3; k++) begin
            rv = (k == 0) ? 32'h0 : (k == 1) ? 32'h4 : 32'h9;
            axw(pwm_pkg::OFF_CMPA, rv, pwm_pkg::RESP_OKAY);
            axw(pwm_pkg::OFF_CMPB, rv, pwm_pkg::RESP_OKAY);
            axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_FAST_CAP, 2'h2, 2'h3,
                3'h1), pwm_pkg::RESP_OKAY);
            repeat (30) @(posedge clk);
            meas(10);
            cmp_wave(ha, rv[15:0] + 16'h1);
            cmp_wave(hb, 16'h9 - rv[15:0]);
        end
        axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_FAST_CAP, 2'h2, 2'h3, 3'h0),
            pwm_pkg::RESP_OKAY);
        axr(pwm_pkg::OFF_FLAGS, ok(32'hF));
        axw(pwm_pkg::OFF_FLAGS, 32'hF, pwm_pkg::RESP_OKAY);
        axr(pwm_pkg::OFF_FLAGS, ok(32'h0));
        axw(pwm_pkg::OFF_CMPA, 32'h9, pwm_pkg::RESP_OKAY);
        axw(pwm_pkg::OFF_CMPB, 32'h4, pwm_pkg::RESP_OKAY);
        axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_FAST_CMPA, 2'h1, 2'h2, 3'h1),
            pwm_pkg::RESP_OKAY);
        repeat (40) @(posedge clk);
        meas(20);
        cmp_wave(ha, 16'hA);
        cmp_wave(hb, 16'hA);
        $display("test single slope done");
        axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_PC_CAP, 2'h2, 2'h3, 3'h0),
            pwm_pkg::RESP_OKAY);
        axw(pwm_pkg::OFF_FLAGS, 32'hF, pwm_pkg::RESP_OKAY);
        for (k = 0; k < 3; k++) begin
            rv = (k == 0) ? 32'h0 : (k == 1) ? 32'h4 : 32'h9;
            axw(pwm_pkg::OFF_CMPA, rv, pwm_pkg::RESP_OKAY);
            axw(pwm_pkg::OFF_CMPB, rv, pwm_pkg::RESP_OKAY);
            axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_PC_CAP, 2'h2, 2'h3,
                3'h1), pwm_pkg::RESP_OKAY);
            repeat (60) @(posedge clk);
            meas(18);
            cmp_wave(ha, {rv[14:0], 1'h0});
            cmp_wave(hb, 16'h12 - {rv[14:0], 1'h0});
        end
        axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_PC_CAP, 2'h2, 2'h3, 3'h0),
            pwm_pkg::RESP_OKAY);
        axr(pwm_pkg::OFF_FLAGS, ok(32'hF));
        axw(pwm_pkg::OFF_CMPB, 32'h4, pwm_pkg::RESP_OKAY);
        axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_PC_CMPA, 2'h1, 2'h2, 3'h1),
            pwm_pkg::RESP_OKAY);
        repeat (80) @(posedge clk);
        meas(36);
        cmp_wave(ha, 16'h12);
        cmp_wave(hb, 16'h10);
        $display("test dual slope done");
        axw(pwm_pkg::OFF_CTRL, ctl(pwm_pkg::MODE_FAST_CAP, 2'h0, 2'h0, 3'h1),
            pwm_pkg::RESP_OKAY);
        repeat (20) @(posedge clk);
        meas(10);
        cmp_wave({15'h0, (ha == 16'h0) || (ha == 16'hA)}, 16'h1);
        cmp_wave({14'h0, oe_a, oe_b}, 16'h0);
        $display("test no action done");
        test_done();
    end
endmodule : timer16_pwm_bench
